// ===== rtl/psrd_defs.vh
// constants for the parallel speed reference decoder
`ifndef PSRD_DEFS_VH
`define PSRD_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PSRD_ADDR_CTRL 12'h000
`define PSRD_ADDR_UNITS 12'h004
`define PSRD_ADDR_FMAX 12'h008
`define PSRD_ADDR_REF 12'h00C
`define PSRD_ADDR_MON 12'h010
`define PSRD_ADDR_STATUS 12'h014

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define PSRD_CTRL_FMT_LSB 0
`define PSRD_CTRL_FMT_MSB 2
`define PSRD_CTRL_BOARD8_BIT 3
`define PSRD_UNITS_MSB 16
`define PSRD_FMAX_MSB 15
`define PSRD_FMT_RST 3'h0
`define PSRD_UNITS_RST 17'h0_0000
`define PSRD_FMAX_RST 16'h1770

// ----------------------------------------------------------------------------
// format and unit kinds
// ----------------------------------------------------------------------------
`define PSRD_FMT_BCD5 3'h6
`define PSRD_FMT_BIN 3'h7
`define PSRD_FMT_FIRST_HZ 3'h3
`define PSRD_UK_HZ 2'h0
`define PSRD_UK_PCT 2'h1
`define PSRD_UK_RPM 2'h2
`define PSRD_UK_USER 2'h3
`define PSRD_USER_MIN 17'h0_0028
`define PSRD_DEC_HUNDREDTHS 2'h2
`define PSRD_DEC_UNITS 2'h0

// ----------------------------------------------------------------------------
// range limits and scale factors
// ----------------------------------------------------------------------------
`define PSRD_LIM_110 18'h0_006E
`define PSRD_LIM_159 18'h0_009F
`define PSRD_LIM_255 18'h0_00FF
`define PSRD_LIM_400 18'h0_0190
`define PSRD_LIM_1100 18'h0_044C
`define PSRD_LIM_1599 18'h0_063F
`define PSRD_LIM_4000 18'h0_0FA0
`define PSRD_LIM_4095 18'h0_0FFF
`define PSRD_LIM_9999 18'h0_270F
`define PSRD_LIM_11000 18'h0_2AF8
`define PSRD_LIM_15999 18'h0_3E7F
`define PSRD_LIM_33000 18'h0_80E8
`define PSRD_LIM_39998 18'h0_9C3E
`define PSRD_FS_8 16'h00FF
`define PSRD_FS_12 16'h0FFF
`define PSRD_FS_16 16'h7530
`define PSRD_TEN_K 14'h2710
`define PSRD_RPM_MUL 16'hC350
`define PSRD_RPM_DIV 3'h6
`define PSRD_PCT_SAT 16'h7FFF
`define PSRD_MASK_8 16'h00FF
`define PSRD_MASK_12 16'h0FFF
`define PSRD_MASK_16 16'hFFFF

`endif

// ===== rtl/psrd_bcd_to_bin.v
// bcd digit string to binary value converter
`timescale 1ns/100ps
module psrd_bcd_to_bin #(
  parameter DIGITS = 5
) (
  input wire [4*DIGITS-1:0] nibbles,
  output wire [17:0] value
);
  wire [17:0] weight [0:DIGITS];
  wire [17:0] partial [0:DIGITS];

  assign weight[0] = 18'h0_0001;
  assign partial[0] = 18'h0_0000;

  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : g_digit
      wire [21:0] term;
      wire [21:0] next_w;
      assign term = nibbles[4*i+3:4*i] * weight[i];
      assign next_w = weight[i] * 4'hA;
      assign weight[i+1] = next_w[17:0];
      assign partial[i+1] = partial[i] + term[17:0];
    end
  endgenerate

  assign value = partial[DIGITS];
endmodule

// ===== rtl/psrd_divider.v
// serial restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/100ps
module psrd_divider #(
  parameter W = 40
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [W-1:0] dividend,
  input wire [W-1:0] divisor,
  output reg [W-1:0] quotient,
  output reg done
);
  localparam CW = $clog2(W + 1);
  localparam [CW-1:0] W_CNT = W;
  localparam [CW-1:0] ONE = 1;

  reg [W:0] rem_reg;
  reg [W-1:0] dvs_reg;
  reg [CW-1:0] cnt_reg;

  wire [W:0] shifted = {rem_reg[W-1:0], quotient[W-1]};
  wire [W:0] trial = shifted - {1'b0, dvs_reg};

  // zero divisor yields an all-ones quotient
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rem_reg <= {(W+1){1'b0}};
      dvs_reg <= {W{1'b0}};
      quotient <= {W{1'b0}};
      cnt_reg <= {CW{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem_reg <= {(W+1){1'b0}};
        dvs_reg <= divisor;
        quotient <= dividend;
        cnt_reg <= W_CNT;
      end else if (cnt_reg != {CW{1'b0}}) begin
        if (!trial[W]) begin
          rem_reg <= trial;
          quotient <= {quotient[W-2:0], 1'b1};
        end else begin
          rem_reg <= shifted;
          quotient <= {quotient[W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - ONE;
        if (cnt_reg == ONE) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== rtl/psrd_decoder.v
// parallel speed reference decoder with apb register file
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`include "psrd_defs.vh"
module psrd_decoder #(
  parameter DIV_W = 40
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] input_terminal_block,
  input wire ref_sign,
  input wire ref_strobe,
  input wire word_width_switch,
  output reg [15:0] reference_pct,
  output reg reference_reverse,
  output reg reference_valid,
  output reg reference_clamped,
  output reg reference_update,
  output reg [31:0] frequency_reference_monitor,
  output reg [1:0] monitor_decimals
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DIV1 = 2'd1;
  localparam ST_DIV2 = 2'd2;

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  reg [2:0] reference_format_select;
  reg board8_reg;
  reg [16:0] display_unit_scaling;
  reg [15:0] fmax_reg;
  reg cfg_bad_reg;

  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pready & pwrite;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reference_format_select <= `PSRD_FMT_RST;
      board8_reg <= 1'b0;
      display_unit_scaling <= `PSRD_UNITS_RST;
      fmax_reg <= `PSRD_FMAX_RST;
    end else if (apb_write) begin
      case (paddr)
        `PSRD_ADDR_CTRL: begin
          reference_format_select <= pwdata[`PSRD_CTRL_FMT_MSB:`PSRD_CTRL_FMT_LSB];
          board8_reg <= pwdata[`PSRD_CTRL_BOARD8_BIT];
        end
        `PSRD_ADDR_UNITS: begin
          display_unit_scaling <= pwdata[`PSRD_UNITS_MSB:0];
        end
        `PSRD_ADDR_FMAX: begin
          fmax_reg <= pwdata[`PSRD_FMAX_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // unit and format decode
  // --------------------------------------------------------------------------
  reg [1:0] state_reg;
  wire w16 = ~board8_reg & word_width_switch;
  wire [15:0] width_mask = board8_reg ? `PSRD_MASK_8 : (w16 ? `PSRD_MASK_16 : `PSRD_MASK_12);
  wire [15:0] data_m = input_terminal_block & width_mask;

  wire [1:0] ukind = (display_unit_scaling == 17'h0_0000) ? `PSRD_UK_HZ :
                     (display_unit_scaling == 17'h0_0001) ? `PSRD_UK_PCT :
                     (display_unit_scaling < `PSRD_USER_MIN) ? `PSRD_UK_RPM : `PSRD_UK_USER;
  wire fmt_mode = (ukind == `PSRD_UK_HZ) | (ukind == `PSRD_UK_PCT);
  wire fmt6 = fmt_mode & (reference_format_select == `PSRD_FMT_BCD5);
  wire fmt7 = fmt_mode & (reference_format_select == `PSRD_FMT_BIN);
  wire cfg_bad = fmt6 & ~w16;

  // user units: fifth decimal digit and low four digits
  wire [1:0] user_d5 = (display_unit_scaling >= 17'h0_7530) ? 2'd3 :
                       (display_unit_scaling >= 17'h0_4E20) ? 2'd2 :
                       (display_unit_scaling >= 17'h0_2710) ? 2'd1 : 2'd0;
  wire [16:0] d5_x10k = user_d5 * `PSRD_TEN_K;
  wire [16:0] user_low4 = display_unit_scaling - d5_x10k;

  // --------------------------------------------------------------------------
  // raw value, clamp and sign
  // --------------------------------------------------------------------------
  wire [19:0] bcd_in = fmt6 ? {2'b00, ref_sign, input_terminal_block, 1'b0}
                            : {4'h0, data_m};
  wire [17:0] bcd_val;

  psrd_bcd_to_bin #(
    .DIGITS(5)
  ) u_bcd (
    .nibbles(bcd_in),
    .value(bcd_val)
  );

  function [17:0] fmt_limit;
    input b8;
    input wide;
    input [2:0] fmt;
    input [1:0] uk;
    begin
      if (uk == `PSRD_UK_RPM || uk == `PSRD_UK_USER) begin
        if (b8) begin
          fmt_limit = `PSRD_LIM_159;
        end else if (!wide) begin
          fmt_limit = `PSRD_LIM_1599;
        end else if (uk == `PSRD_UK_RPM) begin
          fmt_limit = `PSRD_LIM_15999;
        end else begin
          fmt_limit = `PSRD_LIM_9999;
        end
      end else begin
        case (fmt)
          3'h0: fmt_limit = `PSRD_LIM_110;
          3'h1: fmt_limit = b8 ? `PSRD_LIM_159 : `PSRD_LIM_1100;
          3'h2: fmt_limit = b8 ? `PSRD_LIM_159 : (wide ? `PSRD_LIM_11000 : `PSRD_LIM_1599);
          3'h3: fmt_limit = b8 ? `PSRD_LIM_159 : `PSRD_LIM_400;
          3'h4: fmt_limit = b8 ? `PSRD_LIM_159 : (wide ? `PSRD_LIM_4000 : `PSRD_LIM_1599);
          3'h5: fmt_limit = b8 ? `PSRD_LIM_159 : (wide ? `PSRD_LIM_15999 : `PSRD_LIM_1599);
          3'h6: fmt_limit = `PSRD_LIM_39998;
          default: fmt_limit = b8 ? `PSRD_LIM_255 : (wide ? `PSRD_LIM_33000 : `PSRD_LIM_4095);
        endcase
      end
    end
  endfunction

  wire [17:0] raw = fmt7 ? {2'b00, data_m} : bcd_val;
  wire [17:0] lim = fmt_limit(board8_reg, w16, reference_format_select, ukind);
  wire over = raw > lim;
  wire [16:0] mag = over ? lim[16:0] : raw[16:0];
  wire all_ones = fmt7 ? (data_m == width_mask) : (fmt6 & (&input_terminal_block) & ref_sign);
  wire neg = ref_sign & ~fmt6;

  // --------------------------------------------------------------------------
  // scaling to 0.01% of maximum frequency
  // --------------------------------------------------------------------------
  wire [6:0] step_mul = (reference_format_select == 3'h0 || reference_format_select == 3'h3) ? 7'h64 :
                        (reference_format_select == 3'h1 || reference_format_select == 3'h4) ? 7'h0A :
                        7'h01;
  wire [23:0] scaled = mag * step_mul;
  wire [30:0] mag_x10k = mag * `PSRD_TEN_K;
  wire [37:0] hz_num = scaled * `PSRD_TEN_K;
  wire [22:0] mag_poles = mag * display_unit_scaling[5:0];
  wire [38:0] rpm_num = mag_poles * `PSRD_RPM_MUL;
  wire [18:0] fmax_x6 = fmax_reg * `PSRD_RPM_DIV;
  wire [15:0] bin_fs = board8_reg ? `PSRD_FS_8 : (w16 ? `PSRD_FS_16 : `PSRD_FS_12);

  reg [DIV_W-1:0] n1_next;
  reg [DIV_W-1:0] d1_next;
  reg hz_known_next;

  always @* begin
    n1_next = {DIV_W{1'b0}};
    d1_next = {{(DIV_W-1){1'b0}}, 1'b1};
    hz_known_next = 1'b0;
    if (all_ones & (fmt6 | fmt7)) begin
      n1_next = {{(DIV_W-14){1'b0}}, `PSRD_TEN_K};
    end else begin
      case (ukind)
        `PSRD_UK_RPM: begin
          n1_next = {1'b0, rpm_num};
          d1_next = {{(DIV_W-19){1'b0}}, fmax_x6};
        end
        `PSRD_UK_USER: begin
          n1_next = {9'h000, mag_x10k};
          d1_next = {{(DIV_W-17){1'b0}}, user_low4};
        end
        default: begin
          if (fmt7) begin
            n1_next = {9'h000, mag_x10k};
            d1_next = {{(DIV_W-16){1'b0}}, bin_fs};
          end else if (reference_format_select < `PSRD_FMT_FIRST_HZ) begin
            n1_next = {16'h0000, scaled};
          end else begin
            n1_next = {2'b00, hz_num};
            d1_next = {{(DIV_W-16){1'b0}}, fmax_reg};
            hz_known_next = 1'b1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // capture and divide sequence
  // --------------------------------------------------------------------------
  reg div_start;
  reg [DIV_W-1:0] div_n;
  reg [DIV_W-1:0] div_d;
  wire [DIV_W-1:0] div_q;
  wire div_done;

  psrd_divider #(
    .W(DIV_W)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .start(div_start),
    .dividend(div_n),
    .divisor(div_d),
    .quotient(div_q),
    .done(div_done)
  );

  reg neg_reg;
  reg hz_known_reg;
  reg clamp_reg;
  reg [1:0] ukind_reg;
  reg [16:0] mag_reg;
  reg [16:0] hz_reg;
  reg [1:0] dec_reg;
  reg [15:0] pct_reg;

  wire [15:0] pct_sat = (div_q > {{(DIV_W-16){1'b0}}, `PSRD_PCT_SAT}) ? `PSRD_PCT_SAT : div_q[15:0];
  wire [31:0] pct_x_fmax = pct_sat * fmax_reg;
  wire [30:0] hz_from_pct = div_q[30:0];

  reg [30:0] mon_mag;

  always @* begin
    case (ukind_reg)
      `PSRD_UK_HZ: mon_mag = hz_known_reg ? {14'h0000, hz_reg} : hz_from_pct;
      `PSRD_UK_PCT: mon_mag = {15'h0000, pct_reg};
      default: mon_mag = {14'h0000, mag_reg};
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      div_start <= 1'b0;
      div_n <= {DIV_W{1'b0}};
      div_d <= {DIV_W{1'b0}};
      neg_reg <= 1'b0;
      hz_known_reg <= 1'b0;
      clamp_reg <= 1'b0;
      ukind_reg <= `PSRD_UK_HZ;
      mag_reg <= 17'h0_0000;
      hz_reg <= 17'h0_0000;
      dec_reg <= `PSRD_DEC_HUNDREDTHS;
      pct_reg <= 16'h0000;
      cfg_bad_reg <= 1'b0;
      reference_pct <= 16'h0000;
      reference_reverse <= 1'b0;
      reference_valid <= 1'b0;
      reference_clamped <= 1'b0;
      reference_update <= 1'b0;
      frequency_reference_monitor <= 32'h0000_0000;
      monitor_decimals <= `PSRD_DEC_HUNDREDTHS;
    end else begin
      div_start <= 1'b0;
      reference_update <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (ref_strobe) begin
            cfg_bad_reg <= cfg_bad;
            if (cfg_bad) begin
              reference_valid <= 1'b0;
              reference_pct <= 16'h0000;
              reference_reverse <= 1'b0;
              reference_clamped <= 1'b0;
              frequency_reference_monitor <= 32'h0000_0000;
              reference_update <= 1'b1;
            end else begin
              neg_reg <= neg;
              hz_known_reg <= hz_known_next & ~all_ones;
              clamp_reg <= over;
              ukind_reg <= ukind;
              mag_reg <= mag;
              hz_reg <= scaled[16:0];
              dec_reg <= fmt_mode ? `PSRD_DEC_HUNDREDTHS :
                         (ukind == `PSRD_UK_RPM) ? `PSRD_DEC_UNITS : user_d5;
              div_n <= n1_next;
              div_d <= d1_next;
              div_start <= 1'b1;
              state_reg <= ST_DIV1;
            end
          end
        end
        ST_DIV1: begin
          if (div_done) begin
            pct_reg <= pct_sat;
            state_reg <= ST_DIV2;
            div_start <= 1'b1;
            div_n <= {{(DIV_W-32){1'b0}}, pct_x_fmax};
            div_d <= {{(DIV_W-14){1'b0}}, `PSRD_TEN_K};
          end
        end
        ST_DIV2: begin
          if (div_done) begin
            reference_pct <= neg_reg ? (16'h0000 - pct_reg) : pct_reg;
            reference_reverse <= neg_reg;
            reference_clamped <= clamp_reg;
            reference_valid <= 1'b1;
            reference_update <= 1'b1;
            frequency_reference_monitor <= neg_reg ? (32'h0000_0000 - {1'b0, mon_mag})
                                                   : {1'b0, mon_mag};
            monitor_decimals <= dec_reg;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // apb read path, one registered access cycle
  // --------------------------------------------------------------------------
  reg [31:0] rdata_next;
  reg hit_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (paddr)
      `PSRD_ADDR_CTRL: rdata_next = {28'h000_0000, board8_reg, reference_format_select};
      `PSRD_ADDR_UNITS: rdata_next = {15'h0000, display_unit_scaling};
      `PSRD_ADDR_FMAX: rdata_next = {16'h0000, fmax_reg};
      `PSRD_ADDR_REF: rdata_next = {{16{reference_pct[15]}}, reference_pct};
      `PSRD_ADDR_MON: rdata_next = frequency_reference_monitor;
      `PSRD_ADDR_STATUS: rdata_next = {24'h00_0000, 1'b0, reference_reverse, monitor_decimals,
                                       (state_reg != ST_IDLE), reference_clamped, cfg_bad_reg,
                                       reference_valid};
      default: hit_next = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit_next;
      if (apb_setup) begin
        prdata <= (pwrite | ~hit_next) ? 32'h0000_0000 : rdata_next;
      end
    end
  end
endmodule

// ===== verif/psrd_decoder_chk.sv
// port assertions for the parallel speed reference decoder
`timescale 1ns/100ps
module psrd_decoder_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic ref_strobe,
  input wire logic [15:0] reference_pct,
  input wire logic reference_reverse,
  input wire logic reference_valid,
  input wire logic reference_clamped,
  input wire logic reference_update,
  input wire logic [31:0] frequency_reference_monitor
);
  // ----------------------------------------
  // cycles since strobe last seen high
  // ----------------------------------------
  logic [7:0] age_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      age_reg <= 8'hFF;
    end else if (ref_strobe) begin
      age_reg <= 8'h00;
    end else if (age_reg != 8'hFF) begin
      age_reg <= age_reg + 8'h01;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_UPDATE_PULSE: assert property (reference_update |=> !reference_update)
    else $error("update pulse too long");
  AST_UPDATE_CAUSE: assert property (reference_update |-> age_reg <= 8'h5A)
    else $error("update without recent strobe");
  AST_HOLD: assert property (!reference_update |-> $stable(reference_pct)
    && $stable(frequency_reference_monitor) && $stable(reference_reverse))
    else $error("outputs changed without update");
  AST_SIGN: assert property (reference_update && reference_pct[15] |-> reference_reverse)
    else $error("negative reference not reverse");
  AST_INVALID_ZERO: assert property (reference_update && !reference_valid |->
    reference_pct == 16'h0000 && frequency_reference_monitor == 32'h0000_0000)
    else $error("invalid config gave a reference");
  AST_CLAMP_SIGN: assert property (reference_update && reference_clamped &&
    reference_reverse |-> reference_pct[15])
    else $error("clamp lost the sign");
  AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  AST_PREADY_ONCE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
endmodule

bind psrd_decoder psrd_decoder_chk psrd_decoder_chk_inst (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .ref_strobe(ref_strobe), .reference_pct(reference_pct), .reference_reverse(reference_reverse),
  .reference_valid(reference_valid), .reference_clamped(reference_clamped),
  .reference_update(reference_update),
  .frequency_reference_monitor(frequency_reference_monitor));

// ===== verif/psrd_ctrl_model.sv
// external controller model driving the reference pins
`timescale 1ns/100ps
module psrd_ctrl_model (
  input wire logic clk,
  output logic [15:0] data,
  output logic sign,
  output logic strobe
);
  initial begin
    data = 16'h0000;
    sign = 1'b0;
    strobe = 1'b0;
  end
  // data and sign held for the whole strobe, inverted once released
  task automatic send(input logic [15:0] d, input logic s);
    @(posedge clk);
    data <= d;
    sign <= s;
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    data <= ~d;
    sign <= ~s;
  endtask
endmodule

// ===== verif/tb.sv
// testbench for the parallel speed reference decoder
`timescale 1ns/100ps
module tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, word_width_switch;
  logic ref_sign, ref_strobe, reference_reverse, reference_valid, reference_clamped;
  logic reference_update;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, frequency_reference_monitor;
  logic [15:0] input_terminal_block, reference_pct;
  logic [1:0] monitor_decimals;
  int mismatches, checked;
  psrd_decoder psrd_decoder_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_terminal_block(input_terminal_block), .ref_sign(ref_sign),
    .ref_strobe(ref_strobe), .word_width_switch(word_width_switch),
    .reference_pct(reference_pct), .reference_reverse(reference_reverse),
    .reference_valid(reference_valid), .reference_clamped(reference_clamped),
    .reference_update(reference_update),
    .frequency_reference_monitor(frequency_reference_monitor),
    .monitor_decimals(monitor_decimals));
  psrd_ctrl_model psrd_ctrl_model_inst (.clk(clk), .data(input_terminal_block),
    .sign(ref_sign), .strobe(ref_strobe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
  endtask
  task automatic cv(input logic [3:0] c, input logic [16:0] u, input logic w,
      input logic [15:0] d, input logic s, input logic [15:0] p, input logic [2:0] f,
      input logic [31:0] m, input logic [1:0] dp);
    int n;
    apb(1'b1, 12'h000, {28'h000_0000, c});
    apb(1'b1, 12'h004, {15'h0000, u});
    word_width_switch <= w;
    psrd_ctrl_model_inst.send(d, s);
    n = 0;
    #1;
    while (reference_update !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("update", 32'h0000_0001, {31'h0000_0000, reference_update});
    chk("pct", {16'h0000, p}, {16'h0000, reference_pct});
    chk("rev_valid_clamp", {29'h0000_0000, f},
      {29'h0000_0000, reference_reverse, reference_valid, reference_clamped});
    chk("monitor", m, frequency_reference_monitor);
    chk("decimals", {30'h0000_0000, dp}, {30'h0000_0000, monitor_decimals});
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rchk(12'h008, 32'h0000_1770);
    rchk(12'h000, 32'h0000_0000);
    rchk(12'h004, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    rchk(12'h004, 32'h0001_FFFF);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    rchk(12'h00C, 32'h0000_0000);
    rchk(12'h020, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, {31'h0000_0000, er});
    $display("test regs done");
  endtask
  task automatic t_board8;
    cv(4'hF, 17'h0_0000, 1'b0, 16'h00FF, 1'b0, 16'h2710, 3'h2, 32'h0000_1770, 2'h2);
    cv(4'hF, 17'h0_0000, 1'b0, 16'h0033, 1'b1, 16'hF830, 3'h6, 32'hFFFF_FB50, 2'h2);
    cv(4'hE, 17'h0_0000, 1'b0, 16'h1234, 1'b0, 16'h0000, 3'h0, 32'h0000_0000, 2'h2);
    cv(4'h8, 17'h0_0000, 1'b0, 16'h00F5, 1'b0, 16'h2AF8, 3'h3, 32'h0000_19C8, 2'h2);
    cv(4'hB, 17'h0_0000, 1'b0, 16'h0012, 1'b0, 16'h07D0, 3'h2, 32'h0000_04B0, 2'h2);
    $display("test board8 done");
  endtask
  task automatic t_board16;
    cv(4'h0, 17'h0_0000, 1'b1, 16'h0120, 1'b1, 16'hD508, 3'h7, 32'hFFFF_E638, 2'h2);
    cv(4'h2, 17'h0_0000, 1'b0, 16'hA500, 1'b0, 16'h01F4, 3'h2, 32'h0000_012C, 2'h2);
    cv(4'h3, 17'h0_0000, 1'b1, 16'h0030, 1'b0, 16'h1388, 3'h2, 32'h0000_0BB8, 2'h2);
    cv(4'h1, 17'h0_0000, 1'b1, 16'h0555, 1'b0, 16'h15AE, 3'h2, 32'h0000_0D02, 2'h2);
    cv(4'h4, 17'h0_0000, 1'b1, 16'h4500, 1'b0, 16'h7FFF, 3'h3, 32'h0000_9C40, 2'h2);
    cv(4'h5, 17'h0_0000, 1'b0, 16'h1800, 1'b1, 16'hFACB, 3'h6, 32'hFFFF_FCE0, 2'h2);
    cv(4'h7, 17'h0_0000, 1'b1, 16'h7530, 1'b0, 16'h2710, 3'h2, 32'h0000_1770, 2'h2);
    cv(4'h7, 17'h0_0000, 1'b0, 16'hFFFF, 1'b0, 16'h2710, 3'h2, 32'h0000_1770, 2'h2);
    cv(4'h6, 17'h0_0000, 1'b0, 16'h0001, 1'b0, 16'h0000, 3'h0, 32'h0000_0000, 2'h2);
    $display("test board16 done");
  endtask
  task automatic t_units;
    cv(4'h0, 17'h0_0001, 1'b1, 16'h0050, 1'b0, 16'h1388, 3'h2, 32'h0000_1388, 2'h2);
    cv(4'h0, 17'h0_0004, 1'b1, 16'h1800, 1'b0, 16'h2710, 3'h2, 32'h0000_0708, 2'h0);
    cv(4'h0, 17'h0_2EE0, 1'b1, 16'h1000, 1'b0, 16'h1388, 3'h2, 32'h0000_03E8, 2'h1);
    rchk(12'h00C, 32'h0000_1388);
    rchk(12'h010, 32'h0000_03E8);
    rchk(12'h014, 32'h0000_0011);
    $display("test units done");
  endtask
  task automatic t_unsigned;
    apb(1'b1, 12'h008, 32'h0000_9C40);
    cv(4'h6, 17'h0_0000, 1'b1, 16'h0001, 1'b0, 16'h0000, 3'h2, 32'h0000_0002, 2'h2);
    cv(4'h6, 17'h0_0000, 1'b1, 16'h0001, 1'b1, 16'h1388, 3'h2, 32'h0000_4E22, 2'h2);
    cv(4'h6, 17'h0_0000, 1'b1, 16'hCCCC, 1'b1, 16'h270F, 3'h2, 32'h0000_9C3E, 2'h2);
    cv(4'h6, 17'h0_0000, 1'b1, 16'hFFFF, 1'b1, 16'h2710, 3'h3, 32'h0000_9C40, 2'h2);
    $display("test unsigned done");
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    word_width_switch = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_board8();
    t_board16();
    t_units();
    t_unsigned();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog expected done seen timeout");
    test_done();
  end
endmodule
